// *** bench/main_memory_model.sv ***
// Main memory controller model answering fetches and reads.
`timescale 1ns/100ps
`default_nettype none
module main_memory_model
    import useq_pkg::*;
#(
    parameter logic [15:0] DATA_KEY = 16'h3b26
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic memReq,
    input wire memkind_t memKind,
    input wire logic [15:0] memAddr,
    input wire logic [3:0] latency,
    output var logic memRdValid,
    output var logic [15:0] memRdData
);
    logic busy_q;
    logic [3:0] waitCnt_q;
    logic [15:0] reqAddr_q;

    // One request is held at a time; a newer one replaces it, as the real
    // controller keeps no queue. Idle data toggles so stale words show.
    always @(posedge sys_clk) begin
        memRdValid <= 1'b0;
        memRdData <= ~memRdData;
        if (rst) begin
            // Reset gives the data lines a defined value before any answer.
            busy_q <= 1'b0;
            memRdData <= 16'h0000;
        end else if (memReq && memKind != MK_NONE) begin
            busy_q <= 1'b1;
            waitCnt_q <= latency;
            reqAddr_q <= memAddr;
        end else if (busy_q && waitCnt_q != 4'h0) begin
            waitCnt_q <= waitCnt_q - 4'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            memRdValid <= 1'b1;
            memRdData <= reqAddr_q ^ DATA_KEY;
        end
    end
endmodule // main_memory_model
`default_nettype wire

// *** bench/test_microcode_dispatch_sequencer.sv ***
// Self-checking testbench for the microcode dispatch sequencer.
`timescale 1ns/100ps
`default_nettype none
module test_microcode_dispatch_sequencer;
    import useq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] switchReg = 16'h0000;
    logic intPending = 1'b0;
    logic csLoadWe = 1'b0;
    logic [13:0] csLoadAddr = 14'h0000;
    logic [31:0] csLoadData = 32'h0000_0000;
    logic [3:0] memLat = 4'h0;
    logic memReq, memRdValid, gpFlag, resultStrobe, stackError;
    memkind_t memKind;
    region_t moduleRegion;
    logic [15:0] memAddr, memRdData, instrReg, memReturn;
    logic [15:0] progCounter, resultBus;
    logic [13:0] microAddr;
    logic [3:0] moduleIndex;
    logic [9:0] moduleWord;
    logic [5:0] entryPoints;
    logic [17:0] reqLog [$];
    int failures = 0;
    int cmp_count = 0;

    microcode_dispatch_sequencer u_microcode_dispatch_sequencer (
        .sys_clk(sys_clk), .rst(rst), .switchReg(switchReg),
        .intPending(intPending), .memReq(memReq), .memKind(memKind),
        .memAddr(memAddr), .memRdValid(memRdValid),
        .memRdData(memRdData), .csLoadWe(csLoadWe),
        .csLoadAddr(csLoadAddr), .csLoadData(csLoadData),
        .microAddr(microAddr), .moduleIndex(moduleIndex),
        .moduleWord(moduleWord), .moduleRegion(moduleRegion),
        .entryPoints(entryPoints), .instrReg(instrReg),
        .memReturn(memReturn), .progCounter(progCounter),
        .gpFlag(gpFlag), .resultBus(resultBus),
        .resultStrobe(resultStrobe), .stackError(stackError));

    main_memory_model u_main_memory_model (
        .sys_clk(sys_clk), .rst(rst), .memReq(memReq), .memKind(memKind),
        .memAddr(memAddr), .latency(memLat), .memRdValid(memRdValid),
        .memRdData(memRdData));

    // Free-running clock and a log of every memory request seen.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (memReq === 1'b1 && !rst) reqLog.push_back({memKind, memAddr});
    end

    // A hang stops the run well beyond the few hundred cycles it needs.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end

    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    function automatic logic [31:0] mk(input uop_t op, input logic [13:0] t);
        return {op, 14'h0000, t};
    endfunction

    // Words are loaded while reset holds the sequencer still.
    task automatic csWrite(input logic [13:0] a, input logic [31:0] d);
        csLoadWe = 1'b1;
        csLoadAddr = a;
        csLoadData = d;
        @(negedge sys_clk);
    endtask

    task automatic holdReset;
        @(negedge sys_clk);
        rst = 1'b1;
        reqLog.delete();
    endtask

    task automatic releaseReset;
        csLoadWe = 1'b0;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    task automatic waitAddr(input logic [13:0] a);
        int n;
        n = 0;
        while (microAddr !== a && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chk(microAddr, a);
    endtask

    // One hop per module; the last lands on the top word of the store.
    function automatic logic [13:0] modAddr(input int k);
        return (k == 0) ? 14'h0000 : {k[3:0], 10'h3ff - 10'(k % 15)};
    endfunction

    task automatic testModuleMap;
        int k;
        logic [13:0] a;
        region_t rg;
        holdReset();
        for (k = 0; k < 16; k++) begin
            csWrite(modAddr(k), mk(UO_JUMP, modAddr(k < 15 ? k + 1 : 15)));
        end
        releaseReset();
        for (k = 0; k < 16; k++) begin
            a = modAddr(k);
            rg = (k < 2) ? RG_BASE : (k == 4 || k == 5) ? RG_ACCESSORY :
                (k < 8) ? RG_VENDOR_RESV : (k < 12) ? RG_RESV_USER : RG_USER;
            waitAddr(a);
            chk(moduleIndex, a[13:10]);
            chk(moduleWord, a[9:0]);
            chk(moduleRegion, rg);
            chk(entryPoints, (k == 8 || k == 10) ? 6'h10 :
                (k == 12 || k == 13) ? 6'h20 : 6'h00);
        end
    endtask

    // Fetch, dispatch of a memory-group opcode, PC read, fetch with return.
    task automatic testDispatch(input logic [3:0] lat);
        int k;
        holdReset();
        memLat = lat;
        intPending = 1'b0;
        switchReg = 16'h0800;
        csWrite(14'h0000, mk(UO_FETCH_BASE, 14'h0123));
        csWrite(14'h0001, mk(UO_SET_FLAG, 14'h0000));
        for (k = 2; k < 14; k++) begin
            csWrite(14'(k), mk(k == 8 ? UO_DISPATCH : UO_NEXT, 14'h0000));
        end
        csWrite(14'h000e, mk(UO_LOOP_RETURN, 14'h0040));
        csWrite(14'h0020, mk(UO_DIAG_OUT, 14'h0000));
        csWrite(14'h0021, mk(UO_JUMP, 14'h0021));
        for (k = 14'h013a; k < 14'h0147; k++) begin
            csWrite(14'(k), mk(k == 14'h0140 ? UO_READ_PC : UO_NEXT, 14'h0));
        end
        csWrite(14'h0147, mk(UO_FETCH_PC_RETURN, 14'h0000));
        releaseReset();
        waitAddr(14'h0008);
        chk(gpFlag, 1'b1);
        @(negedge sys_clk);
        chk(microAddr, 14'h013a);
        chk(progCounter, 16'h0001);
        chk(gpFlag, 1'b0);
        chk(instrReg, 16'h3a05);
        chk({memReq, memKind, memAddr}, {1'b1, MK_READ, 16'h0205});
        waitAddr(14'h0140);
        chk(memReturn, 16'h3923);
        waitAddr(14'h0147);
        chk(memReturn, 16'h3b27);
        chk(instrReg, 16'h3a05);
        chk(progCounter, 16'h0002);
        @(negedge sys_clk);
        chk(microAddr, 14'h0009);
        waitAddr(14'h0020);
        k = 0;
        while (resultStrobe !== 1'b1 && k < 4) begin
            @(negedge sys_clk);
            k++;
        end
        chk(resultStrobe, 1'b1);
        chk(resultBus, 16'h3b24);
        chk(instrReg, 16'h3b24);
        chk(reqLog.size(), 4);
        chk(reqLog[0], {MK_FETCH, 16'h0123});
        chk(reqLog[1], {MK_READ, 16'h0205});
        chk(reqLog[2], {MK_READ, 16'h0001});
        chk(reqLog[3], {MK_FETCH, 16'h0002});
    endtask

    // Other switch bits are all set to one to show only bit 11 counts.
    task automatic testLoop(input logic irq, input logic sw,
        input logic [13:0] exp);
        holdReset();
        intPending = irq;
        switchReg = {4'hf, sw, 11'h7ff};
        csWrite(14'h0000, mk(UO_LOOP_RETURN, 14'h0040));
        csWrite(14'h0010, mk(UO_JUMP, 14'h0010));
        csWrite(14'h0020, mk(UO_JUMP, 14'h0020));
        csWrite(14'h0040, mk(UO_JUMP, 14'h0040));
        releaseReset();
        waitAddr(exp);
    endtask

    // Reset values, then a return with nothing on the stack.
    task automatic testStackEmpty;
        int n;
        holdReset();
        csWrite(14'h0000, mk(UO_RETURN, 14'h0030));
        csWrite(14'h0030, mk(UO_JUMP, 14'h0030));
        releaseReset();
        chk(progCounter, PC_RESET);
        chk(instrReg, WORD_RESET);
        chk(memReturn, WORD_RESET);
        chk({memReq, gpFlag, stackError}, 3'h0);
        n = 0;
        while (stackError !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        chk(stackError, 1'b1);
        waitAddr(14'h0030);
    endtask

    // Call, plain fetch at the PC, return, then calls until the stack fills.
    task automatic testCallFetch;
        int n;
        holdReset();
        memLat = 4'h0;
        csWrite(14'h0000, mk(UO_CALL, 14'h0050));
        csWrite(14'h0001, mk(UO_CALL, 14'h0001));
        csWrite(14'h0050, mk(UO_FETCH_PC, 14'h0000));
        csWrite(14'h0051, mk(UO_RETURN, 14'h0000));
        releaseReset();
        waitAddr(14'h0050);
        @(negedge sys_clk);
        chk(microAddr, 14'h0051);
        chk({memReq, memKind, memAddr}, {1'b1, MK_FETCH, PC_RESET});
        @(negedge sys_clk);
        chk(microAddr, 14'h0001);
        chk(stackError, 1'b0);
        repeat (2) @(negedge sys_clk);
        chk(instrReg, 16'h3b26);
        n = 0;
        while (stackError !== 1'b1 && n < 16) begin
            @(negedge sys_clk);
            n++;
        end
        chk(stackError, 1'b1);
    endtask

    initial begin
        testModuleMap();
        testDispatch(4'h0);
        testDispatch(4'h1);
        testLoop(1'b0, 1'b0, NORMAL_LOOP_ADDR);
        testLoop(1'b0, 1'b1, DIAG_LOOP_ADDR);
        testLoop(1'b1, 1'b0, 14'h0040);
        testLoop(1'b1, 1'b1, 14'h0040);
        testCallFetch();
        testStackEmpty();
        print_verdict();
    end
endmodule // test_microcode_dispatch_sequencer
`default_nettype wire

// *** hdl/control_store.sv ***
// Control store memory with a registered read port and a load port.
`timescale 1ns/100ps
`default_nettype none
module control_store
    import useq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    cs_bus_if.store bus
);
    logic [CS_DW-1:0] mem [CS_WORDS];
    logic [CS_DW-1:0] rdData_q;

    // Loading and reading in the same cycle to one address returns old data.
    always_ff @(posedge sys_clk) begin
        if (bus.wrEn) begin
            mem[bus.wrAddr] <= bus.wrData;
        end
    end

    // The read register is cleared so the first word after reset is a no-op.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData_q <= MIR_RESET;
        end else begin
            rdData_q <= mem[bus.rdAddr];
        end
    end

    assign bus.rdData = rdData_q;
endmodule // control_store
`default_nettype wire

// *** hdl/cs_bus_if.sv ***
// Port bundle between the sequencer and its control store memory.
`timescale 1ns/100ps
`default_nettype none
interface cs_bus_if;
    import useq_pkg::*;
    logic [CS_AW-1:0] rdAddr;
    logic [CS_DW-1:0] rdData;
    logic wrEn;
    logic [CS_AW-1:0] wrAddr;
    logic [CS_DW-1:0] wrData;

    modport seq (output rdAddr, output wrEn, output wrAddr, output wrData,
        input rdData);
    modport store (input rdAddr, input wrEn, input wrAddr, input wrData,
        output rdData);
endinterface
`default_nettype wire

// *** hdl/microcode_dispatch_sequencer.sv ***
// Microprogram sequencer with control store map and macroinstruction dispatch.
`timescale 1ns/100ps
`default_nettype none
module microcode_dispatch_sequencer
    import useq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] switchReg,
    input wire logic intPending,
    output logic memReq,
    output memkind_t memKind,
    output logic [15:0] memAddr,
    input wire logic memRdValid,
    input wire logic [15:0] memRdData,
    input wire logic csLoadWe,
    input wire logic [13:0] csLoadAddr,
    input wire logic [31:0] csLoadData,
    output logic [13:0] microAddr,
    output logic [3:0] moduleIndex,
    output logic [9:0] moduleWord,
    output region_t moduleRegion,
    output logic [5:0] entryPoints,
    output logic [15:0] instrReg,
    output logic [15:0] memReturn,
    output logic [15:0] progCounter,
    output logic gpFlag,
    output logic [15:0] resultBus,
    output logic resultStrobe,
    output logic stackError
);
    cs_bus_if csBus ();

    control_store u_control_store (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(csBus.store)
    );

    seqstate_t state_q;
    logic [13:0] uAddr_q;
    logic [15:0] pc_q;
    logic [15:0] cir_q;
    logic [15:0] mrr_q;
    logic gpFlag_q;
    memkind_t pendKind_q;
    logic memReq_q;
    memkind_t memKind_q;
    logic [15:0] memAddr_q;
    logic [15:0] result_q;
    logic resultStb_q;
    logic stkErr_q;
    logic [13:0] stack_q [STK_DEPTH];
    logic [3:0] stkCnt_q;

    // Field decode of the microinstruction now in the read register.
    wire [31:0] mir = csBus.rdData;
    wire uop_t op = uop_t'(mir[OP_MSB:OP_LSB]);
    wire [13:0] target = mir[TGT_MSB:0];
    wire running = (state_q == ST_RUN);
    wire isDispatch = running && (op == UO_DISPATCH);
    wire isCall = running && (op == UO_CALL);
    wire isReturn = running && (op == UO_RETURN || op == UO_FETCH_PC_RETURN);
    wire isLoop = running && (op == UO_LOOP_RETURN);
    wire isFetchPc = running && (op == UO_FETCH_PC || op == UO_FETCH_PC_RETURN);
    wire isFetchBase = running && (op == UO_FETCH_BASE);
    wire isReadPc = running && (op == UO_READ_PC);
    wire isDiag = running && (op == UO_DIAG_OUT);

    // Memory group test and operand address on the current instruction.
    wire isMrg = (cir_q[GRP_MSB:GRP_LSB] != GRP_NON_MRG);
    wire [15:0] operandAddr = cir_q[PAGE_BIT] ?
        {pc_q[15:PAGE_BIT], cir_q[PAGE_BIT-1:0]} :
        {6'h00, cir_q[PAGE_BIT-1:0]};
    wire startMrgRead = isDispatch && isMrg;

    // Table entry is formed from the high opcode byte of the instruction.
    wire [7:0] jtOffset = cir_q[JT_OFF_MSB:JT_OFF_LSB];
    wire [13:0] jtAddr = JT_BASE + {6'h00, jtOffset};

    // Stack top and the return address pushed by calls and dispatch.
    wire [STK_PW-1:0] topIdx = stkCnt_q[STK_PW-1:0] - 3'h1;
    wire [13:0] stackTop = stack_q[topIdx];
    wire [13:0] retAddr = uAddr_q + 14'h0001;
    wire doPush = (isDispatch || isCall) && (stkCnt_q != STK_FULL);
    wire doPop = isReturn && (stkCnt_q != 4'h0);
    wire stkFault = ((isDispatch || isCall) && (stkCnt_q == STK_FULL)) ||
        (isReturn && (stkCnt_q == 4'h0));
    // An empty stack falls back to the target, so an underflow never
    // sends the sequencer to an entry that was never written.
    wire [13:0] popAddr = (stkCnt_q == 4'h0) ? target : stackTop;

    // Decode loop choice: interrupts go to the target, else loop by switch.
    wire [13:0] loopAddr = switchReg[SR_LOOP_BIT] ? DIAG_LOOP_ADDR :
        NORMAL_LOOP_ADDR;
    wire [13:0] loopNext = intPending ? target : loopAddr;

    // Next microaddress; the read register holds its word one cycle later.
    logic [13:0] nextAddr;
    always_comb begin
        nextAddr = uAddr_q + 14'h0001;
        if (!running) begin
            nextAddr = START_ADDR;
        end else begin
            unique case (op)
                UO_JUMP, UO_CALL: nextAddr = target;
                UO_RETURN, UO_FETCH_PC_RETURN: nextAddr = popAddr;
                UO_DISPATCH: nextAddr = jtAddr;
                UO_LOOP_RETURN: nextAddr = loopNext;
                default: nextAddr = uAddr_q + 14'h0001;
            endcase
        end
    end

    // Memory request selection; one microorder issues at most one request.
    logic [15:0] reqAddr;
    memkind_t reqKind;
    always_comb begin
        reqKind = MK_NONE;
        reqAddr = memAddr_q;
        if (isFetchPc) begin
            reqKind = MK_FETCH;
            reqAddr = pc_q;
        end else if (isFetchBase) begin
            reqKind = MK_FETCH;
            reqAddr = {6'h00, mir[BASE_MSB:0]};
        end else if (isReadPc) begin
            reqKind = MK_READ;
            reqAddr = pc_q;
        end else if (startMrgRead) begin
            reqKind = MK_READ;
            reqAddr = operandAddr;
        end
    end

    // Control store map decode of the current microaddress.
    wire [3:0] modIdx = uAddr_q[MOD_MSB:MOD_LSB];

    assign csBus.rdAddr = nextAddr;
    assign csBus.wrEn = csLoadWe;
    assign csBus.wrAddr = csLoadAddr;
    assign csBus.wrData = csLoadData;

    // Sequencer state and microaddress register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_START;
            uAddr_q <= START_ADDR;
        end else begin
            state_q <= ST_RUN;
            uAddr_q <= nextAddr;
        end
    end

    // Program counter and general purpose flag.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_q <= PC_RESET;
            gpFlag_q <= 1'b0;
        end else begin
            if (isDispatch || isReadPc) begin
                pc_q <= pc_q + 16'h0001;
            end
            if (isDispatch) begin
                gpFlag_q <= 1'b0;
            end else if (running && op == UO_SET_FLAG) begin
                gpFlag_q <= 1'b1;
            end
        end
    end

    // Return stack; overflow and underflow leave it unchanged and flag a fault.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stkCnt_q <= 4'h0;
            stkErr_q <= 1'b0;
        end else begin
            if (doPush) begin
                stack_q[stkCnt_q[STK_PW-1:0]] <= retAddr;
                stkCnt_q <= stkCnt_q + 4'h1;
            end else if (doPop) begin
                stkCnt_q <= stkCnt_q - 4'h1;
            end
            if (stkFault) begin
                stkErr_q <= 1'b1;
            end
        end
    end

    // Memory request register; the controller sees a one-cycle strobe.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            memReq_q <= 1'b0;
            memKind_q <= MK_NONE;
            memAddr_q <= WORD_RESET;
            pendKind_q <= MK_NONE;
        end else begin
            memReq_q <= (reqKind != MK_NONE);
            memKind_q <= reqKind;
            memAddr_q <= reqAddr;
            if (reqKind != MK_NONE) begin
                pendKind_q <= reqKind;
            end else if (memRdValid) begin
                pendKind_q <= MK_NONE;
            end
        end
    end

    // Returned words: only reads and fetches load these registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mrr_q <= WORD_RESET;
            cir_q <= WORD_RESET;
        end else if (memRdValid) begin
            mrr_q <= memRdData;
            if (pendKind_q == MK_FETCH) begin
                cir_q <= memRdData;
            end
        end
    end

    // Diagnostic loop output of the current instruction onto the result bus.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_q <= WORD_RESET;
            resultStb_q <= 1'b0;
        end else begin
            resultStb_q <= isDiag;
            if (isDiag) begin
                result_q <= cir_q;
            end
        end
    end

    assign memReq = memReq_q;
    assign memKind = memKind_q;
    assign memAddr = memAddr_q;
    assign microAddr = uAddr_q;
    assign moduleIndex = modIdx;
    assign moduleWord = uAddr_q[WORD_MSB:0];
    assign moduleRegion = REGION_MAP[modIdx];
    assign entryPoints = ENTRY_MAP[modIdx];
    assign instrReg = cir_q;
    assign memReturn = mrr_q;
    assign progCounter = pc_q;
    assign gpFlag = gpFlag_q;
    assign resultBus = result_q;
    assign resultStrobe = resultStb_q;
    assign stackError = stkErr_q;

    // Checks kept next to the logic they guard.
    a_dispatch_pc_flag: assert property (
        @(posedge sys_clk) disable iff (rst)
        isDispatch |=> (pc_q == $past(pc_q) + 16'h0001) && !gpFlag_q)
        else $error("dispatch did not step pc or clear flag");
    a_dispatch_push: assert property (
        @(posedge sys_clk) disable iff (rst)
        doPush && isDispatch |=> stackTop == $past(uAddr_q) + 14'h0001)
        else $error("dispatch pushed wrong return address");
    a_dispatch_table: assert property (
        @(posedge sys_clk) disable iff (rst)
        isDispatch |=> uAddr_q >= JT_BASE && uAddr_q <= JT_LAST)
        else $error("dispatch left the jump table");
    a_mrg_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        startMrgRead |=> memReq_q && memKind_q == MK_READ &&
        memAddr_q == $past(operandAddr))
        else $error("memory group operand read not started");
    a_return_pop: assert property (
        @(posedge sys_clk) disable iff (rst)
        doPop |=> uAddr_q == $past(stackTop))
        else $error("return did not use popped address");
    a_loop_select: assert property (
        @(posedge sys_clk) disable iff (rst)
        isLoop && !intPending |=> uAddr_q ==
        ($past(switchReg[SR_LOOP_BIT]) ? DIAG_LOOP_ADDR : NORMAL_LOOP_ADDR))
        else $error("wrong decode loop selected");
    a_loop_irq: assert property (
        @(posedge sys_clk) disable iff (rst)
        isLoop && intPending |=> uAddr_q == $past(target))
        else $error("pending interrupt did not leave the decode loop");
    a_fetch_loads_ir: assert property (
        @(posedge sys_clk) disable iff (rst)
        memRdValid && pendKind_q == MK_FETCH |=>
        cir_q == $past(memRdData) && mrr_q == $past(memRdData))
        else $error("fetched word not in instruction register");
    a_return_reg_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        !memRdValid |=> $stable(mrr_q))
        else $error("return register changed without a read");
    a_fetch_pc_req: assert property (
        @(posedge sys_clk) disable iff (rst)
        isFetchPc |=> memReq_q && memKind_q == MK_FETCH &&
        memAddr_q == $past(pc_q))
        else $error("pc fetch not issued at pc");
    a_read_pc_step: assert property (
        @(posedge sys_clk) disable iff (rst)
        isReadPc |=> memKind_q == MK_READ && pc_q == $past(pc_q) + 16'h0001)
        else $error("pc read did not step pc");
endmodule // microcode_dispatch_sequencer
`default_nettype wire

// *** hdl/useq_pkg.sv ***
// Constants, field layouts and types shared by the microcode sequencer files.
package useq_pkg;

    // Control store geometry.
    localparam int CS_AW = 14;
    localparam int CS_DW = 32;
    localparam int CS_WORDS = 16384;
    localparam int MOD_MSB = 13;
    localparam int MOD_LSB = 10;
    localparam int WORD_MSB = 9;

    // Fixed microaddresses.
    localparam logic [13:0] START_ADDR = 14'h0000;
    localparam logic [13:0] JT_BASE = 14'h0100;
    localparam logic [13:0] JT_LAST = 14'h01ff;
    localparam logic [13:0] NORMAL_LOOP_ADDR = 14'h0010;
    localparam logic [13:0] DIAG_LOOP_ADDR = 14'h0020;

    // Switch register bit that selects the decode loop.
    localparam int SR_LOOP_BIT = 11;

    // Microinstruction field layout.
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 28;
    localparam int TGT_MSB = 13;
    localparam int BASE_MSB = 9;

    // Macroinstruction fields used for dispatch and operand addressing.
    localparam int JT_OFF_MSB = 15;
    localparam int JT_OFF_LSB = 8;
    localparam int GRP_MSB = 14;
    localparam int GRP_LSB = 12;
    localparam int PAGE_BIT = 10;
    localparam logic [2:0] GRP_NON_MRG = 3'h0;

    // Return stack.
    localparam int STK_DEPTH = 8;
    localparam int STK_PW = 3;
    localparam logic [3:0] STK_FULL = 4'h8;

    // Reset values.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [31:0] MIR_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        UO_NEXT = 4'h0,
        UO_JUMP = 4'h1,
        UO_CALL = 4'h2,
        UO_RETURN = 4'h3,
        UO_DISPATCH = 4'h4,
        UO_FETCH_PC = 4'h5,
        UO_FETCH_BASE = 4'h6,
        UO_READ_PC = 4'h7,
        UO_FETCH_PC_RETURN = 4'h8,
        UO_LOOP_RETURN = 4'h9,
        UO_DIAG_OUT = 4'ha,
        UO_SET_FLAG = 4'hb
    } uop_t;

    typedef enum logic [1:0] {
        MK_NONE = 2'h0,
        MK_FETCH = 2'h1,
        MK_READ = 2'h2
    } memkind_t;

    typedef enum logic [2:0] {
        RG_BASE = 3'h0,
        RG_VENDOR_RESV = 3'h1,
        RG_ACCESSORY = 3'h2,
        RG_RESV_USER = 3'h3,
        RG_USER = 3'h4
    } region_t;

    typedef enum logic {
        ST_START = 1'b0,
        ST_RUN = 1'b1
    } seqstate_t;

    typedef region_t region_map_t [16];
    typedef logic [5:0] entry_map_t [16];

    // Usage of each 1K-word module, index 0 first.
    localparam region_map_t REGION_MAP = '{
        RG_BASE, RG_BASE, RG_VENDOR_RESV, RG_VENDOR_RESV,
        RG_ACCESSORY, RG_ACCESSORY, RG_VENDOR_RESV, RG_VENDOR_RESV,
        RG_RESV_USER, RG_RESV_USER, RG_RESV_USER, RG_RESV_USER,
        RG_USER, RG_USER, RG_USER, RG_USER};

    // User software entry points per module; zero means none.
    localparam entry_map_t ENTRY_MAP = '{
        6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
        6'h10, 6'h00, 6'h10, 6'h00, 6'h20, 6'h20, 6'h00, 6'h00};

endpackage
